// File: hdl/tic_consts.svh
// What this block does
// - Three presettable 16-bit down-counters, counter 2 chained to counter 1, counts 2 to 65535 by mode.
// - Counter 0 clock selects internal 10MHz source or external clock input.
// - Counter 1 output clocks counter 2; counter 2 output is converter start.
// - Trigger is gate rising edge; clock is a positive pulse on clock input.
// - Mode 0 load drives output low; gate enables counting; high at zero.
// - Mode 1 output falls after trigger, rises at zero; retrigger reloads count.
// - Mode 2 divides by N, one-clock low pulse, reloads, stops when gate low.
// - Mode 3 square wave, odd count high (N+1)/2 low (N-1)/2, step two.
// - Mode 4 output high, counts after load, low one period at zero, gate inhibits.
// - Mode 5 counts after gate rising edge, retriggerable, one-clock low at terminal count.
// - Counters at offsets 8, 9, A; control writes at offset B.
// - Control byte: select 7-6, access 5-4, mode 3-1, decimal select bit 0.
// - Select 00, 01, 10 pick counters; 11 marks a readback command.
// - Access 00 latch, 01 low only, 10 high only, 11 low then high.
// - Mode field 000,001,x10,x11,100,101 map to modes 0 to 5.
// - Control bit 0 zero counts binary, one counts binary-coded decimal.
// - Latch command copies count to hold register without disturbing counting.
// - Low-then-high access uses a byte toggle; software keeps pairs complete.
// - Readback bits 7-6 ones; bit5 low latches counts, bit4 low latches status.
// - Status: output bit 7, null count bit 6, then access, mode, decimal.
// - Status and count latched in two-byte mode read status, low, high.
// - Repeated latches ignored until hold read; pending status is read first.
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH
`define TIC_OFS_CNT0     4'h8
`define TIC_OFS_CNT1     4'h9
`define TIC_OFS_CNT2     4'hA
`define TIC_OFS_CTRL     4'hB
`define TIC_SEL_RB       2'h3
`define TIC_ACC_LATCH    2'h0
`define TIC_ACC_LO       2'h1
`define TIC_ACC_HI       2'h2
`define TIC_ACC_LOHI     2'h3
`define TIC_INT_CLK_HZ   10000000
`define TIC_SYS_CLK_HZ   200000000
`define TIC_INT_DIV      (`TIC_SYS_CLK_HZ / `TIC_INT_CLK_HZ)
`define TIC_INT_DIV_W    5
`define TIC_RESET_CTRL   6'h00
`endif

// File: hdl/tic_pkg.sv
package tic_pkg;
  typedef struct packed {
    logic [1:0] access_mode;
    logic [2:0] op_mode;
    logic       bcd;
  } tic_cfg_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tic_bus_t;
endpackage

// File: hdl/tic_triple_counter.sv
`timescale 1ns/1ps
`include "tic_consts.svh"
module tic_triple_counter (
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  input  wire tic_pkg::tic_bus_t bus,
  output logic [7:0]         rdata,
  input  wire logic          ext_clk0,
  input  wire logic          c0_clk_sel_ext,
  input  wire logic [2:0]    gate_pin,
  output logic [2:0]         cnt_out,
  output logic               conv_start
);
  import tic_pkg::*;

  // ****************************************
  // Pin synchronisers and clock sources
  // ****************************************
  logic [2:0] gate_s1_reg;
  logic [2:0] gate_s2_reg;
  logic [2:0] gate_d_reg;
  logic       ext_s1_reg;
  logic       ext_s2_reg;
  logic       ext_d_reg;
  logic [`TIC_INT_DIV_W-1:0] div_reg;
  logic       int_tick;
  logic       ext_tick;
  logic [2:0] tick;
  logic [2:0] out_reg;
  logic [2:0] out_d_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gate_s1_reg <= 3'h0;
      gate_s2_reg <= 3'h0;
      gate_d_reg  <= 3'h0;
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_d_reg   <= 1'b0;
      div_reg     <= '0;
      out_d_reg   <= 3'h7;
    end else if (clk_en) begin
      gate_s1_reg <= gate_pin;
      gate_s2_reg <= gate_s1_reg;
      gate_d_reg  <= gate_s2_reg;
      ext_s1_reg  <= ext_clk0;
      ext_s2_reg  <= ext_s1_reg;
      ext_d_reg   <= ext_s2_reg;
      div_reg     <= int_tick ? '0 : div_reg + 1'b1;
      out_d_reg   <= out_reg;
    end
  end

  assign int_tick = (div_reg == `TIC_INT_DIV_W'(`TIC_INT_DIV - 1));
  assign ext_tick = ext_s2_reg & ~ext_d_reg;
  assign tick[0] = c0_clk_sel_ext ? ext_tick : int_tick;
  // Counter 1 runs from the internal source as no other clock is brought out for it.
  assign tick[1] = int_tick;
  // counter 1 output clocks counter 2
  assign tick[2] = out_reg[1] & ~out_d_reg[1];

  // ****************************************
  // Host bus decode
  // ****************************************
  logic       ctrl_wr;
  logic       is_rb;
  logic [2:0] port_hit;
  logic [2:0] prog_hit;
  logic [2:0] rb_hit;
  assign ctrl_wr     = bus.wr && (bus.addr == `TIC_OFS_CTRL);
  assign port_hit[0] = bus.addr == `TIC_OFS_CNT0;
  assign port_hit[1] = bus.addr == `TIC_OFS_CNT1;
  assign port_hit[2] = bus.addr == `TIC_OFS_CNT2;
  assign is_rb = bus.wdata[7:6] == `TIC_SEL_RB;
  assign rb_hit = (ctrl_wr && is_rb && !bus.wdata[0]) ? bus.wdata[3:1] : 3'h0;

  logic [7:0] rd_mux [3];

  // ****************************************
  // Counter channels
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ch
      tic_cfg_t    cfg_reg;
      logic [15:0] cr_reg;
      logic [15:0] ce_reg;
      logic [15:0] ol_reg;
      logic [7:0]  st_reg;
      logic        ol_full_reg;
      logic        st_full_reg;
      logic        wr_tog_reg;
      logic        rd_tog_reg;
      logic        null_reg;
      logic        load_reg;
      logic        arm_reg;
      logic        trig_reg;
      logic        trig;
      logic        gate;
      logic        sel;
      logic        prog;
      logic        latch_cnt;
      logic        latch_st;
      logic        wr_port;
      logic        rd_port;
      logic        wr_done;
      logic [2:0]  m;
      logic        step2;
      logic [15:0] dec1;
      logic [15:0] dec2;
      logic [15:0] nxt;
      logic        at_term;
      logic [15:0] ld_val;
      logic [7:0]  cnt_byte;
      logic [15:0] view;

      assign gate    = gate_s2_reg[i];
      assign trig    = gate_s2_reg[i] & ~gate_d_reg[i];
      assign sel     = ctrl_wr && !is_rb && (bus.wdata[7:6] == 2'(i));
      assign prog    = sel && (bus.wdata[5:4] != `TIC_ACC_LATCH);
      assign latch_cnt = ((sel && bus.wdata[5:4] == `TIC_ACC_LATCH) ||
                          (rb_hit[i] && !bus.wdata[5])) && !ol_full_reg;
      assign latch_st  = rb_hit[i] && !bus.wdata[4] && !st_full_reg;
      assign wr_port = bus.wr && port_hit[i];
      assign rd_port = bus.rd && port_hit[i];
      assign m = cfg_reg.op_mode[1] ? {1'b0, cfg_reg.op_mode[1:0]} : cfg_reg.op_mode;
      assign step2 = (m == 3'd3);

      function automatic logic [15:0] dec_bcd(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int k = 0; k < 4; k++) begin
          if (b) begin
            if (r[4*k +: 4] == 4'h0) begin
              r[4*k +: 4] = 4'h9;
            end else begin
              r[4*k +: 4] = r[4*k +: 4] - 4'h1;
              b = 1'b0;
            end
          end
        end
        return r;
      endfunction

      assign dec1 = cfg_reg.bcd ? dec_bcd(ce_reg) : ce_reg - 16'h1;
      assign dec2 = cfg_reg.bcd ? dec_bcd(dec1) : ce_reg - 16'h2;
      assign at_term = step2 ? (ce_reg <= 16'h2) : (ce_reg == 16'h1);
      assign nxt     = step2 ? {dec2[15:1], 1'b0} : dec1;
      // An odd square-wave count starts high, so that half counts one extra step.
      assign ld_val  = (step2 && cr_reg[0]) ? cr_reg + 16'h1 : cr_reg;
      assign wr_done = wr_port && (cfg_reg.access_mode != `TIC_ACC_LOHI || wr_tog_reg);

      // direct reads see the live element
      assign view = ol_full_reg ? ol_reg : ce_reg;
      assign cnt_byte = (cfg_reg.access_mode == `TIC_ACC_HI) ? view[15:8] :
                        (cfg_reg.access_mode == `TIC_ACC_LO) ? view[7:0] :
                        (rd_tog_reg ? view[15:8] : view[7:0]);
      assign rd_mux[i] = st_full_reg ? st_reg : cnt_byte;

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          cfg_reg     <= `TIC_RESET_CTRL;
          cr_reg      <= 16'h0;
          ce_reg      <= 16'h0;
          ol_reg      <= 16'h0;
          st_reg      <= 8'h0;
          ol_full_reg <= 1'b0;
          st_full_reg <= 1'b0;
          wr_tog_reg  <= 1'b0;
          rd_tog_reg  <= 1'b0;
          null_reg    <= 1'b1;
          load_reg    <= 1'b0;
          arm_reg     <= 1'b0;
          trig_reg    <= 1'b0;
          out_reg[i]  <= 1'b1;
        end else if (clk_en) begin
          if (prog) begin
            cfg_reg     <= bus.wdata[5:0];
            wr_tog_reg  <= 1'b0;
            rd_tog_reg  <= 1'b0;
            ol_full_reg <= 1'b0;
            null_reg    <= 1'b1;
            arm_reg     <= 1'b0;
            out_reg[i]  <= (bus.wdata[3:1] != 3'h0);
          end
          if (latch_cnt) begin
            ol_reg      <= ce_reg;
            ol_full_reg <= 1'b1;
          end
          if (latch_st) begin
            st_reg      <= {out_reg[i], null_reg, cfg_reg};
            st_full_reg <= 1'b1;
          end
          if (wr_port) begin
            if (cfg_reg.access_mode == `TIC_ACC_HI ||
                (cfg_reg.access_mode == `TIC_ACC_LOHI && wr_tog_reg)) begin
              cr_reg[15:8] <= bus.wdata;
            end else begin
              cr_reg[7:0] <= bus.wdata;
            end
            if (cfg_reg.access_mode == `TIC_ACC_LOHI) begin
              wr_tog_reg <= ~wr_tog_reg;
            end
            if (cfg_reg.access_mode == `TIC_ACC_LO) begin
              cr_reg[15:8] <= 8'h0;
            end
            if (cfg_reg.access_mode == `TIC_ACC_HI) begin
              cr_reg[7:0] <= 8'h0;
            end
          end
          if (rd_port) begin
            if (st_full_reg) begin
              st_full_reg <= 1'b0;
            end else if (cfg_reg.access_mode == `TIC_ACC_LOHI) begin
              rd_tog_reg <= ~rd_tog_reg;
              if (rd_tog_reg) begin
                ol_full_reg <= 1'b0;
              end
            end else begin
              ol_full_reg <= 1'b0;
            end
          end
          if (wr_done) begin
            null_reg <= 1'b1;
            load_reg <= 1'b1;
            if (m == 3'd0) begin
              out_reg[i] <= 1'b0;
            end
          end
          if (trig) begin
            trig_reg <= 1'b1;
          end
          if (tick[i] && !wr_done) begin
            trig_reg <= trig;
            if ((load_reg && (m == 3'd0 || m == 3'd4 || m == 3'd2 || m == 3'd3)) ||
                (trig_reg && m != 3'd0 && m != 3'd4)) begin
              ce_reg   <= ld_val;
              load_reg <= 1'b0;
              null_reg <= 1'b0;
              arm_reg  <= 1'b1;
              if (m == 3'd1) begin
                out_reg[i] <= 1'b0;
              end
              if (m == 3'd2 || m == 3'd3 || m == 3'd5) begin
                out_reg[i] <= 1'b1;
              end
            end else if (gate || m == 3'd1 || m == 3'd5) begin
              if (arm_reg || m == 3'd0) begin
                ce_reg <= nxt;
              end
              if (m == 3'd0 && ce_reg == 16'h1) begin
                out_reg[i] <= 1'b1;
              end
              if (m == 3'd1 && ce_reg == 16'h1 && arm_reg) begin
                out_reg[i] <= 1'b1;
                arm_reg    <= 1'b0;
              end
              if (m == 3'd2 && arm_reg) begin
                out_reg[i] <= (ce_reg != 16'h2);
                if (ce_reg == 16'h1) begin
                  ce_reg <= cr_reg;
                end
              end
              if (m == 3'd3 && arm_reg && at_term) begin
                out_reg[i] <= ~out_reg[i];
                ce_reg     <= !cr_reg[0] ? cr_reg :
                              (out_reg[i] ? cr_reg - 16'h1 : cr_reg + 16'h1);
              end
              if ((m == 3'd4 || m == 3'd5) && arm_reg) begin
                out_reg[i] <= (ce_reg != 16'h1);
                if (ce_reg == 16'h0) begin
                  out_reg[i] <= 1'b1;
                  arm_reg    <= 1'b0;
                end
              end
            end else if (m == 3'd2 || m == 3'd3) begin
              out_reg[i] <= 1'b1;
              trig_reg   <= 1'b0;
              load_reg   <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_next;
  assign rdata_next = port_hit[0] ? rd_mux[0] :
                      port_hit[1] ? rd_mux[1] :
                      port_hit[2] ? rd_mux[2] : 8'h00;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (clk_en && bus.rd) begin
      rdata <= rdata_next;
    end
  end

  assign cnt_out    = out_reg;
  assign conv_start = out_reg[2];
endmodule

// File: tb/tic_triple_counter_properties.sv
`timescale 1ns/1ps
`include "tic_consts.svh"
module tic_triple_counter_properties (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              clk_en,
  input wire tic_pkg::tic_bus_t bus,
  input wire logic [7:0]        rdata,
  input wire logic              ext_clk0,
  input wire logic              c0_clk_sel_ext,
  input wire logic [2:0]        gate_pin,
  input wire logic [2:0]        cnt_out,
  input wire logic              conv_start
);
  import tic_pkg::*;
  // ********
  // Mode tracking
  // ********
  logic [2:0] mode0_reg;
  logic [2:0] mode1_reg;
  logic       ctl_wr;
  assign ctl_wr = bus.wr && clk_en && bus.addr == `TIC_OFS_CTRL && bus.wdata[5:4] != 2'h0;
  // Reset to code 7, a mode 3 encoding that no property checks, so no mode property is armed before programming.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode0_reg <= 3'h7;
      mode1_reg <= 3'h7;
    end else if (ctl_wr && bus.wdata[7:6] == 2'h0) begin
      mode0_reg <= bus.wdata[3:1];
    end else if (ctl_wr && bus.wdata[7:6] == 2'h1) begin
      mode1_reg <= bus.wdata[3:1];
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_low_tick;
    !cnt_out[1] [*8] ##13 cnt_out[1];
  endsequence
  property p_conv;
    conv_start == cnt_out[2];
  endproperty
  a_conv: assert property (p_conv) else $error("conv_start differs from output 2");
  property p_hold;
    !(bus.rd && clk_en) |=> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmap;
    bus.rd && clk_en && !bus.addr[3] |=> rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_m0_low;
    ctl_wr && bus.wdata[7:6] == 2'h0 && bus.wdata[3:1] == 3'h0 |-> ##[1:3] !cnt_out[0];
  endproperty
  a_m0_low: assert property (p_m0_low) else $error("mode 0 output not low");
  property p_m0_stay;
    mode0_reg == 3'h0 && cnt_out[0] && !bus.wr && !$past(bus.wr) && !$past(bus.wr, 2)
      |=> cnt_out[0];
  endproperty
  a_m0_stay: assert property (p_m0_stay) else $error("mode 0 output left high");
  property p_m2;
    mode1_reg == 3'h2 && $fell(cnt_out[1]) |-> s_low_tick;
  endproperty
  a_m2: assert property (p_m2) else $error("mode 2 low pulse not one tick");
  property p_m4;
    ctl_wr && bus.wdata[7:6] == 2'h0 && bus.wdata[3:1] == 3'h4 |-> ##[1:3] cnt_out[0];
  endproperty
  a_m4: assert property (p_m4) else $error("mode 4 output not high");
  property p_freeze;
    !clk_en |=> $stable(cnt_out) && $stable(rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
bind tic_triple_counter tic_triple_counter_properties u_props (.sys_clk, .nrst, .clk_en,
  .bus, .rdata, .ext_clk0, .c0_clk_sel_ext, .gate_pin, .cnt_out, .conv_start);

// File: tb/tic_host_model.sv
`timescale 1ns/1ps
module tic_host_model (
  input  wire logic         sys_clk,
  input  wire logic [7:0]   rdata,
  output tic_pkg::tic_bus_t bus
);
  import tic_pkg::*;
  initial bus = '0;
  // Idle cycles show inverted address and data so stale values never look valid.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a, v[15:8]);
  endtask
endmodule

// File: tb/tic_triple_counter_tb.sv
`timescale 1ns/1ps
`include "tic_consts.svh"
`define TIC_CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tic_triple_counter_tb;
  import tic_pkg::*;
  localparam logic [3:0] a_ctl = `TIC_OFS_CTRL;
  localparam logic [3:0] a_c0  = `TIC_OFS_CNT0;
  localparam logic [3:0] a_c1  = `TIC_OFS_CNT1;
  localparam logic [3:0] a_c2  = `TIC_OFS_CNT2;
  logic       sys_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic       clk_en  = 1'b1;
  logic       ext_clk0 = 1'b0;
  logic       c0_sel  = 1'b0;
  logic [2:0] gate    = 3'h7;
  tic_bus_t   bus;
  logic [7:0] rdata;
  logic [2:0] cnt_out;
  logic       conv_start;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [7:0] b;
  logic [7:0] ctl [3] = '{8'h12, 8'h18, 8'h1A};
  int         lows [3] = '{100, 20, 20};
  int         n_errors = 0;
  int         n_compared = 0;
  int         cyc;
  int         t;
  tic_triple_counter dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .ext_clk0(ext_clk0), .c0_clk_sel_ext(c0_sel), .gate_pin(gate),
    .cnt_out(cnt_out), .conv_start(conv_start));
  tic_host_model host (.sys_clk(sys_clk), .rdata(rdata), .bus(bus));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_lvl(input int i, input logic l);
    cyc = 0;
    while (cnt_out[i] !== l) begin
      @(negedge sys_clk);
      cyc++;
      if (cyc > 3000) begin
        n_errors++;
        $display("unexpected wait on output %0d", i);
        finish_test();
      end
    end
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      ext_clk0 = 1'b1;
      idle(10);
      ext_clk0 = 1'b0;
      idle(10);
    end
  endtask
  initial begin
    idle(4);
    `TIC_CHECK("reset out", 3'h7, cnt_out);
    nrst = 1'b1;
    // ********
    // Latching and rate generator
    // ********
    host.wr(a_ctl, 8'h74);
    host.wr16(a_c1, 16'h03E8);
    idle(100);
    host.wr(a_ctl, 8'h40);
    idle(200);
    host.wr(a_ctl, 8'h40);
    host.rd16(a_c1, v1);
    host.wr(a_ctl, 8'h40);
    host.rd16(a_c1, v2);
    `TIC_CHECK("latched", 1'b1, v1 > 16'h03DD && v1 < 16'h03E8);
    `TIC_CHECK("latch gap", 1'b1, v1 - v2 >= 16'h000A && v1 - v2 <= 16'h000C);
    host.wr(a_ctl, 8'h74);
    host.wr(a_ctl, 8'hE4);
    host.rd(a_c1, b);
    `TIC_CHECK("null status", 7'h74, b[6:0]);
    host.wr16(a_c1, 16'h000A);
    idle(60);
    host.wr(a_ctl, 8'hC4);
    host.rd(a_c1, b);
    `TIC_CHECK("status first", 7'h34, b[6:0]);
    host.rd16(a_c1, v1);
    `TIC_CHECK("count after", 1'b1, v1 >= 16'h0001 && v1 <= 16'h000A);
    wait_lvl(1, 0);
    wait_lvl(1, 1);
    t = cyc;
    wait_lvl(1, 0);
    `TIC_CHECK("div period", 200, t + cyc);
    host.wr(a_ctl, 8'hB4);
    host.wr16(a_c2, 16'h0004);
    wait_lvl(2, 0);
    wait_lvl(2, 1);
    t = cyc;
    wait_lvl(2, 0);
    `TIC_CHECK("chain period", 800, t + cyc);
    // ********
    // Square wave and freeze
    // ********
    wait_lvl(1, 1);
    host.wr(a_ctl, 8'h76);
    host.wr16(a_c1, 16'h0005);
    wait_lvl(1, 0);
    wait_lvl(1, 1);
    wait_lvl(1, 0);
    `TIC_CHECK("square high", 60, cyc);
    wait_lvl(1, 1);
    `TIC_CHECK("square low", 40, cyc);
    clk_en = 1'b0;
    b = {5'h00, cnt_out};
    idle(50);
    `TIC_CHECK("frozen", b[2:0], cnt_out);
    clk_en = 1'b1;
    // ********
    // Counter 0: mode 0, clock select, decimal
    // ********
    gate[0] = 1'b0;
    host.wr(a_ctl, 8'h30);
    host.wr16(a_c0, 16'h0003);
    idle(200);
    `TIC_CHECK("gated", 1'b0, cnt_out[0]);
    gate[0] = 1'b1;
    wait_lvl(0, 1);
    `TIC_CHECK("m0 delay", 1'b1, cyc > 40 && cyc < 110);
    host.wr(a_ctl, 8'hE2);
    host.rd(a_c0, b);
    `TIC_CHECK("status", 8'hB0, b);
    host.rd(4'h3, b);
    `TIC_CHECK("unmapped", 8'h00, b);
    c0_sel = 1'b1;
    host.wr(a_ctl, 8'h10);
    host.wr(a_c0, 8'h03);
    idle(200);
    pulse(2);
    `TIC_CHECK("ext part", 1'b0, cnt_out[0]);
    pulse(3);
    `TIC_CHECK("ext done", 1'b1, cnt_out[0]);
    c0_sel = 1'b0;
    host.wr(a_ctl, 8'h31);
    host.wr16(a_c0, 16'h0100);
    idle(100);
    host.wr(a_ctl, 8'h00);
    host.rd16(a_c0, v1);
    `TIC_CHECK("decimal", 1'b1, v1 >= 16'h0094 && v1 <= 16'h0099);
    // ********
    // Strobe and one-shot modes
    // ********
    for (int i = 0; i < 3; i++) begin
      gate[0] = 1'b0;
      host.wr(a_ctl, ctl[i]);
      host.wr(a_c0, 8'h05);
      idle(20);
      gate[0] = 1'b1;
      wait_lvl(0, 0);
      wait_lvl(0, 1);
      `TIC_CHECK("low width", lows[i], cyc);
    end
    finish_test();
  end
endmodule
